// ===== logic/ors_defs.vh
// Purpose: Constants for the outage restart sequencer
// Assumes: 200 MHz clock, APB register window of 32-bit words
// Notes: Offsets are byte addresses
`ifndef ORS_DEFS_VH
`define ORS_DEFS_VH

// Register byte offsets
`define ORS_OFS_CTRL 8'h00
`define ORS_OFS_ALLOW 8'h04
`define ORS_OFS_START_FREQ 8'h08
`define ORS_OFS_STATUS 8'h0C
`define ORS_OFS_SAVED_FREQ 8'h10
`define ORS_OFS_IRQ_STAT 8'h14
`define ORS_OFS_IRQ_MASK 8'h18

// CTRL field positions
`define ORS_CTRL_MODE_LSB 0
`define ORS_CTRL_SEARCH_LSB 4
`define ORS_CTRL_SOURCE_LSB 8
`define ORS_CTRL_OCL_BIT 12
`define ORS_CTRL_KEYRUN_BIT 16

// Reset values
`define ORS_CTRL_RST 32'h0000_0000
`define ORS_ALLOW_RST 9'h000
`define ORS_START_FREQ_RST 16'h0000
`define ORS_IRQ_MASK_RST 5'h00

// Interrupt status bits
`define ORS_IRQ_OUTAGE 0
`define ORS_IRQ_BEGIN 1
`define ORS_IRQ_CANCEL 2
`define ORS_IRQ_DONE 3
`define ORS_IRQ_TRIP 4
`define ORS_IRQ_W 5

// Restart modes and source codes
`define ORS_MODE_TRIP 3'h0
`define ORS_MODE_TRIP_AFTER 3'h1
`define ORS_MODE_START_FREQ 3'h5
`define ORS_SRC_TERMINAL 2'h0
`define ORS_SRC_KEY_FWD 2'h2
`define ORS_SRC_KEY_REV 2'h3

// Timing
`define ORS_CLK_PERIOD_NS 5
`define ORS_TICK_NS 1000000
`define ORS_TICK_CYCLES (`ORS_TICK_NS / `ORS_CLK_PERIOD_NS)
`define ORS_RUN_WAIT_MS 11'd2000
`define ORS_ALLOW_UNIT_MS 7'd100

`endif

// ===== logic/ors_tick.v
// Purpose: Millisecond timebase enable
// Assumes: Single clock, synchronous reset
// Notes: One-cycle pulse every CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module ors_tick #(
  parameter integer CYCLES = 200000
) (
  input wire clock,
  input wire rst,
  output reg tick
);
  reg [31:0] cnt_r;

  always @(posedge clock) begin
    if (rst) begin
      cnt_r <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (cnt_r >= CYCLES - 1) begin
      cnt_r <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule // ors_tick
`default_nettype wire

// ===== logic/ors_sequencer.v
// Purpose: Momentary outage detection and restart sequencing for a motor drive
// Assumes: 200 MHz clock, pins synchronised here, drive status on same clock
// Notes: APB slave with zero-wait access phase
`timescale 1ns/1ps
`default_nettype none
`include "ors_defs.vh"
module ors_sequencer #(
  parameter integer TICK_CYCLES = `ORS_TICK_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output wire irq,
  input wire bus_undervoltage,
  input wire forward_run_cmd,
  input wire reverse_run_cmd,
  input wire coast_stop_cmd,
  input wire contactor_interlock,
  input wire auto_search_enable_cmd,
  input wire drive_running,
  input wire charge_done,
  input wire [15:0] output_freq,
  input wire freq_at_reference,
  input wire search_done,
  input wire [15:0] search_freq,
  output reg drive_output_enable,
  output reg restart_start,
  output reg [15:0] restart_freq,
  output reg restart_with_search,
  output reg current_limit_restart,
  output reg restart_cancel,
  output reg outage_restart_active,
  output reg undervoltage_alarm
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_OUTAGE = 3'd1;
  localparam [2:0] ST_CHARGE = 3'd2;
  localparam [2:0] ST_READY = 3'd3;
  localparam [2:0] ST_SEARCH = 3'd4;
  localparam [2:0] ST_RUNUP = 3'd5;
  localparam [2:0] ST_TRIP = 3'd6;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [5:0] pin_s1_r;
  reg [5:0] pin_s2_r;
  wire uv_s = pin_s2_r[0];
  wire fwd_s = pin_s2_r[1];
  wire rev_s = pin_s2_r[2];
  wire coast_s = pin_s2_r[3];
  wire ilock_s = pin_s2_r[4];
  wire stm_s = pin_s2_r[5];

  always @(posedge clock) begin
    if (rst) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
    end else begin
      pin_s1_r <= {auto_search_enable_cmd, contactor_interlock, coast_stop_cmd,
                   reverse_run_cmd, forward_run_cmd, bus_undervoltage};
      pin_s2_r <= pin_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [31:0] ctrl_r;
  reg [8:0] allow_r;
  reg [15:0] start_freq_r;
  reg [15:0] saved_freq_r;
  reg [4:0] irq_stat_r;
  reg [4:0] irq_mask_r;
  reg [2:0] state_r;
  reg [4:0] irq_set;

  wire [2:0] restart_mode_select = ctrl_r[`ORS_CTRL_MODE_LSB +: 3];
  wire [1:0] auto_search_select = ctrl_r[`ORS_CTRL_SEARCH_LSB +: 2];
  wire [1:0] run_source_select = ctrl_r[`ORS_CTRL_SOURCE_LSB +: 2];
  wire overcurrent_limit_select = ctrl_r[`ORS_CTRL_OCL_BIT];
  wire keypad_run = ctrl_r[`ORS_CTRL_KEYRUN_BIT];

  wire wr_en = psel & penable & pwrite;
  wire setup = psel & ~penable;
  reg addr_ok;
  reg [31:0] rd_mux;

  assign pready = 1'b1;
  assign irq = |(irq_stat_r & irq_mask_r);

  always @* begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `ORS_OFS_CTRL: rd_mux = ctrl_r;
      `ORS_OFS_ALLOW: rd_mux = {23'h00_0000, allow_r};
      `ORS_OFS_START_FREQ: rd_mux = {16'h0000, start_freq_r};
      `ORS_OFS_STATUS: rd_mux = {26'h000_0000, drive_output_enable, undervoltage_alarm,
                                 outage_restart_active, state_r};
      `ORS_OFS_SAVED_FREQ: rd_mux = {16'h0000, saved_freq_r};
      `ORS_OFS_IRQ_STAT: rd_mux = {27'h000_0000, irq_stat_r};
      `ORS_OFS_IRQ_MASK: rd_mux = {27'h000_0000, irq_mask_r};
      default: addr_ok = 1'b0;
    endcase
  end

  // Read data and error are captured in the setup cycle so the access phase needs no wait
  always @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~addr_ok;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      ctrl_r <= `ORS_CTRL_RST;
      allow_r <= `ORS_ALLOW_RST;
      start_freq_r <= `ORS_START_FREQ_RST;
      irq_mask_r <= `ORS_IRQ_MASK_RST;
      irq_stat_r <= 5'h00;
    end else begin
      if (wr_en && paddr == `ORS_OFS_CTRL)
        ctrl_r <= pwdata & 32'h0001_1337;
      // Clamp on the whole word so large writes cannot wrap below the limit
      if (wr_en && paddr == `ORS_OFS_ALLOW)
        allow_r <= (pwdata > 32'd300) ? 9'd300 : pwdata[8:0];
      if (wr_en && paddr == `ORS_OFS_START_FREQ)
        start_freq_r <= pwdata[15:0];
      if (wr_en && paddr == `ORS_OFS_IRQ_MASK)
        irq_mask_r <= pwdata[4:0];
      // A new event beats a write-one clear in the same cycle
      if (wr_en && paddr == `ORS_OFS_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~pwdata[4:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase and timers
  wire tick;
  reg [10:0] wait_ms_r;
  reg [15:0] outage_ms_r;
  wire [15:0] allow_ms = {7'd0, allow_r} * {9'd0, `ORS_ALLOW_UNIT_MS};
  wire allow_over = outage_ms_r >= allow_ms;

  ors_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst(rst),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  wire search_on = stm_s | (auto_search_select == 2'd1) | (auto_search_select == 2'd2);
  wire key_retained = keypad_run & ((run_source_select == `ORS_SRC_KEY_FWD) |
                                    (run_source_select == `ORS_SRC_KEY_REV));
  wire run_cmd = fwd_s | rev_s | key_retained;
  wire outage_seen = (uv_s & drive_running) | ilock_s;
  wire power_back = ~uv_s & ~ilock_s;
  wire wait_over = wait_ms_r >= `ORS_RUN_WAIT_MS;

  always @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
      wait_ms_r <= 11'd0;
      outage_ms_r <= 16'd0;
      saved_freq_r <= 16'h0000;
      drive_output_enable <= 1'b1;
      restart_start <= 1'b0;
      restart_freq <= 16'h0000;
      restart_with_search <= 1'b0;
      current_limit_restart <= 1'b0;
      restart_cancel <= 1'b0;
      outage_restart_active <= 1'b0;
      undervoltage_alarm <= 1'b0;
      irq_set <= 5'h00;
    end else begin
      restart_start <= 1'b0;
      restart_cancel <= 1'b0;
      irq_set <= 5'h00;
      if (tick && state_r != ST_IDLE && outage_ms_r != 16'hFFFF)
        outage_ms_r <= outage_ms_r + 16'd1;
      case (state_r)
        ST_IDLE: begin
          outage_ms_r <= 16'd0;
          wait_ms_r <= 11'd0;
          drive_output_enable <= 1'b1;
          if (outage_seen) begin
            saved_freq_r <= output_freq;
            drive_output_enable <= 1'b0;
            irq_set[`ORS_IRQ_OUTAGE] <= 1'b1;
            if (restart_mode_select == `ORS_MODE_TRIP) begin
              undervoltage_alarm <= 1'b1;
              irq_set[`ORS_IRQ_TRIP] <= 1'b1;
              state_r <= ST_TRIP;
            end else begin
              outage_restart_active <= 1'b1;
              state_r <= ST_OUTAGE;
            end
          end
        end
        ST_OUTAGE: begin
          if (coast_s) begin
            outage_restart_active <= 1'b0;
            restart_cancel <= 1'b1;
            irq_set[`ORS_IRQ_CANCEL] <= 1'b1;
            state_r <= ST_IDLE;
          end else if (power_back) begin
            if (restart_mode_select == `ORS_MODE_TRIP_AFTER) begin
              undervoltage_alarm <= 1'b1;
              outage_restart_active <= 1'b0;
              irq_set[`ORS_IRQ_TRIP] <= 1'b1;
              state_r <= ST_TRIP;
            end else begin
              state_r <= ST_CHARGE;
            end
          end
        end
        ST_CHARGE: begin
          wait_ms_r <= 11'd0;
          if (outage_seen)
            state_r <= ST_OUTAGE;
          else if (charge_done)
            state_r <= ST_READY;
        end
        ST_READY: begin
          if (tick && !wait_over)
            wait_ms_r <= wait_ms_r + 11'd1;
          if (outage_seen) begin
            state_r <= ST_OUTAGE;
          end else if (allow_over || (wait_over && !run_cmd)) begin
            outage_restart_active <= 1'b0;
            restart_cancel <= 1'b1;
            irq_set[`ORS_IRQ_CANCEL] <= 1'b1;
            state_r <= ST_IDLE;
          end else if (run_cmd) begin
            drive_output_enable <= 1'b1;
            irq_set[`ORS_IRQ_BEGIN] <= 1'b1;
            restart_with_search <= search_on;
            if (search_on) begin
              state_r <= ST_SEARCH;
            end else begin
              restart_start <= 1'b1;
              current_limit_restart <= 1'b0;
              if (restart_mode_select == `ORS_MODE_START_FREQ) begin
                restart_freq <= start_freq_r;
              end else begin
                restart_freq <= saved_freq_r;
                current_limit_restart <= overcurrent_limit_select;
              end
              state_r <= ST_RUNUP;
            end
          end
        end
        ST_SEARCH: begin
          if (search_done) begin
            restart_freq <= search_freq;
            restart_start <= 1'b1;
            current_limit_restart <= 1'b0;
            state_r <= ST_RUNUP;
          end
        end
        ST_RUNUP: begin
          if (freq_at_reference) begin
            outage_restart_active <= 1'b0;
            restart_with_search <= 1'b0;
            current_limit_restart <= 1'b0;
            irq_set[`ORS_IRQ_DONE] <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_TRIP: begin
          // Alarm holds until power is back and every run command is removed
          drive_output_enable <= 1'b0;
          if (power_back && !run_cmd) begin
            undervoltage_alarm <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // ors_sequencer
`default_nettype wire

// ===== dv/ors_seq_asserts.sv
// Purpose: Port assertions for the outage restart sequencer
// Assumes: One clock, rst synchronous active high
// Notes: Bound to every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module ors_seq_asserts (
  input wire clock,
  input wire rst,
  input wire pready,
  input wire freq_at_reference,
  input wire drive_output_enable,
  input wire restart_start,
  input wire restart_cancel,
  input wire outage_restart_active,
  input wire undervoltage_alarm
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);
  alarm_output_a: assert property (undervoltage_alarm |-> !drive_output_enable)
    else $error("output on while alarm");
  start_pulse_a: assert property (restart_start |=> !restart_start)
    else $error("start held");
  cancel_pulse_a: assert property (restart_cancel |=> !restart_cancel)
    else $error("cancel held");
  start_active_a: assert property (restart_start |-> outage_restart_active)
    else $error("start while inactive");
  cancel_idle_a: assert property (restart_cancel |-> ##[0:1] !outage_restart_active)
    else $error("active after cancel");
  outage_off_a: assert property ($rose(outage_restart_active) |-> !drive_output_enable)
    else $error("output on in outage");
  // Active may only end on reaching reference, on cancel or on a trip
  active_end_a: assert property ($fell(outage_restart_active) |->
    $past(freq_at_reference) || restart_cancel || $past(restart_cancel) ||
    undervoltage_alarm) else $error("active ended early");
  alarm_off_a: assert property ($rose(undervoltage_alarm) |-> !drive_output_enable)
    else $error("output on with alarm");
  cover property (restart_start);
  cover property (restart_cancel);
  cover property ($rose(undervoltage_alarm));
endmodule // ors_seq_asserts
bind ors_sequencer ors_seq_asserts u_chk (.*);
`default_nettype wire

// ===== dv/ors_far_model.sv
// Purpose: Run-command source and output contactor beside the sequencer
// Assumes: supply_ok low while the mains supply is lost
// Notes: An unlatched run drops with the supply, back dly clocks after it
`timescale 1ns/1ps
`default_nettype none
module ors_far_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic run_req,
  input wire logic latch_run,
  input wire logic use_contactor,
  input wire logic [15:0] dly,
  output logic forward_run_cmd,
  output logic contactor_interlock
);
  logic [15:0] cnt_r;
  always @(posedge clock) begin
    if (rst || !supply_ok) cnt_r <= 16'h0;
    else if (cnt_r != dly) cnt_r <= cnt_r + 16'h1;
    // Relays lose power too, so only a latch keeps the run through the outage
    forward_run_cmd <= run_req && (latch_run || cnt_r == dly);
    contactor_interlock <= use_contactor && !supply_ok;
  end
endmodule // ors_far_model
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the outage restart sequencer
// Assumes: TICK_CYCLES of 10, so 1 ms is 10 clocks
// Notes: Each test starts from a fresh reset
`timescale 1ns/1ps
`default_nettype none
`include "ors_defs.vh"
module tb_top;
  localparam int TK = 10;
  logic clock, rst, psel, penable, pwrite, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, q;
  wire pready, pslverr, irq, restart_start, restart_with_search, current_limit_restart;
  wire restart_cancel, outage_restart_active, undervoltage_alarm, drive_output_enable;
  wire forward_run_cmd, contactor_interlock;
  wire [31:0] prdata;
  wire [15:0] restart_freq;
  logic bus_undervoltage, reverse_run_cmd, coast_stop_cmd, auto_search_enable_cmd;
  logic drive_running, charge_done, freq_at_reference, search_done, sup, run_req, hold_run, use_ct;
  logic [15:0] output_freq, search_freq;
  int num_errors, samples_checked, cyc, n;
  wire [1:0] ev = {restart_cancel, restart_start};
  ors_sequencer #(.TICK_CYCLES(TK)) u_dut (.*);
  ors_far_model u_far (.clock(clock), .rst(rst), .supply_ok(sup), .run_req(run_req),
    .latch_run(hold_run), .use_contactor(use_ct), .dly(16'h00C8),
    .forward_run_cmd(forward_run_cmd), .contactor_interlock(contactor_interlock));
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge clock);
    penable <= 1;
    // Ends once pready is high; the bench timeout ends a hung wait
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic setup(input logic [31:0] c, input logic [31:0] al, input logic run);
    rst <= 1;
    {bus_undervoltage, coast_stop_cmd, auto_search_enable_cmd, charge_done} <= 4'h0;
    {freq_at_reference, search_done, use_ct, sup, drive_running} <= 5'h03;
    {hold_run, run_req} <= {run, run};
    repeat (12) @(posedge clock);
    rst <= 0;
    apb(1, `ORS_OFS_CTRL, c);
    apb(1, `ORS_OFS_ALLOW, al);
    apb(1, `ORS_OFS_START_FREQ, 32'h0000_0456);
  endtask
  task automatic outage(input int hold, input logic act);
    {bus_undervoltage, sup} <= 2'h2;
    repeat (hold) @(posedge clock);
    chk("active", act, outage_restart_active);
    chk("out_en", !act, drive_output_enable);
    {bus_undervoltage, sup, drive_running} <= 3'h2;
    repeat (8) @(posedge clock);
    charge_done <= 1;
  endtask
  task automatic wait_ev(input int i, input int lim);
    n = 0;
    while (ev[i] !== 1'h1 && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, reverse_run_cmd} = 0;
    output_freq = 16'h0123;
    search_freq = 16'h0789;
    setup(32'h0, 32'h0000_0200, 1'h0);
    apb(1, `ORS_OFS_CTRL, 32'hFFFF_FFFF);
    apb(0, `ORS_OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0001_1337, q);
    apb(0, `ORS_OFS_STATUS, 32'h0);
    chk("status", 32'h0000_0020, q);
    apb(0, 8'h1C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_rd", 32'h0, q);
    apb(0, `ORS_OFS_ALLOW, 32'h0);
    chk("clamp", 32'h0000_012C, q);
    $display("regs done");
    setup(32'h0000_0005, 32'h0000_012C, 1'h1);
    apb(1, `ORS_OFS_IRQ_MASK, 32'h0000_0002);
    outage(20, 1'h1);
    chk("masked", 1'h0, irq);
    wait_ev(0, 2000);
    chk("freq", 32'h0000_0456, restart_freq);
    chk("search", 1'h0, restart_with_search);
    chk("active", 1'h1, outage_restart_active);
    @(posedge clock);
    chk("irq", 1'h1, irq);
    apb(0, `ORS_OFS_IRQ_STAT, 32'h0);
    chk("stat", 32'h0000_0003, q);
    apb(1, `ORS_OFS_IRQ_STAT, 32'h0000_0003);
    @(posedge clock);
    chk("irq_clr", 1'h0, irq);
    freq_at_reference <= 1;
    repeat (3) @(posedge clock);
    chk("active_end", 1'h0, outage_restart_active);
    $display("mode5 done");
    for (int k = 0; k < 3; k++) begin
      setup(32'h0000_0005 | (k << 4), 32'h0000_012C, 1'h1);
      auto_search_enable_cmd <= (k == 0);
      search_freq <= search_freq + 16'h1;
      outage(20, 1'h1);
      search_done <= 1;
      wait_ev(0, 2000);
      chk("sfreq", search_freq, restart_freq);
      chk("search", 1'h1, restart_with_search);
    end
    $display("search done");
    setup(32'h0000_1004, 32'h0000_012C, 1'h0);
    run_req <= 1;
    outage(20, 1'h1);
    wait_ev(0, 2000);
    chk("saved", 32'h0000_0123, restart_freq);
    chk("limit", 1'h1, current_limit_restart);
    $display("mode4 done");
    setup(32'h0001_0205, 32'h0000_012C, 1'h0);
    outage(20, 1'h1);
    wait_ev(0, 300);
    chk("keypad", 1'h1, n < 300);
    $display("keypad done");
    setup(32'h0000_0005, 32'h0000_012C, 1'h1);
    {bus_undervoltage, sup} <= 2'h2;
    repeat (20) @(posedge clock);
    {coast_stop_cmd, drive_running} <= 2'h2;
    wait_ev(1, 100);
    chk("coast", 1'h1, n < 100);
    repeat (2) @(posedge clock);
    chk("coast_idle", 1'h0, outage_restart_active);
    $display("coast done");
    setup(32'h0000_0005, 32'h0000_012C, 1'h0);
    outage(20, 1'h1);
    wait_ev(1, 25000);
    chk("wait", 1'h1, n > 2000 * TK - 100 && n < 2000 * TK + 100);
    chk("idle", 1'h0, outage_restart_active);
    $display("no_run done");
    setup(32'h0000_0005, 32'h0000_0001, 1'h0);
    outage(1500, 1'h1);
    wait_ev(1, 500);
    chk("allow", 1'h1, n < 500);
    $display("allow done");
    for (int k = 0; k < 2; k++) begin
      setup(32'h0000_0005, 32'h0000_012C, 1'h0);
      {drive_running, use_ct} <= {1'h0, k[0]};
      outage(20, k[0]);
    end
    $display("idle_outage done");
    setup(32'h0000_0001, 32'h0000_012C, 1'h0);
    reverse_run_cmd <= 1;
    outage(20, 1'h1);
    repeat (4) @(posedge clock);
    chk("late_alarm", 1'h1, undervoltage_alarm);
    chk("late_idle", 1'h0, outage_restart_active);
    chk("late_off", 1'h0, drive_output_enable);
    reverse_run_cmd <= 0;
    repeat (6) @(posedge clock);
    chk("late_clear", 1'h0, undervoltage_alarm);
    $display("mode1 done");
    setup(32'h0, 32'h0000_012C, 1'h0);
    bus_undervoltage <= 1;
    repeat (10) @(posedge clock);
    chk("uv_alarm", 1'h1, undervoltage_alarm);
    chk("off", 1'h0, drive_output_enable);
    $display("mode0 done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
